//--- hdl/utp_pkg.sv
// constants, register map and types of the serial transmit path
// assumes one 20 MHz clock and an avalon-mm slave with byte addresses
package utp_pkg;
   localparam int unsigned ADDR_W     = 6;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned DATA_W     = 8;
   // byte offsets on the register bus
   localparam logic [5:0] OFS_TX_HOLD   = 6'h00;
   localparam logic [5:0] OFS_INT_EN    = 6'h04;
   localparam logic [5:0] OFS_INT_STAT  = 6'h08;
   localparam logic [5:0] OFS_FIFO_CTL  = 6'h0c;
   localparam logic [5:0] OFS_LINE_CTL  = 6'h10;
   localparam logic [5:0] OFS_MODEM_CTL = 6'h14;
   localparam logic [5:0] OFS_LINE_STAT = 6'h18;
   localparam logic [5:0] OFS_DIV_LOW   = 6'h1c;
   localparam logic [5:0] OFS_DIV_HIGH  = 6'h20;
   localparam logic [5:0] OFS_DIV_FRAC  = 6'h24;
   localparam logic [5:0] OFS_SEL_8X    = 6'h28;
   localparam logic [5:0] OFS_SEL_4X    = 6'h2c;
   localparam logic [5:0] OFS_SOFT_RST  = 6'h30;
   // field positions
   localparam int unsigned IE_TX_EMPTY   = 1;
   localparam int unsigned IS_NONE       = 0;
   localparam int unsigned IS_TX_EMPTY   = 1;
   localparam int unsigned FC_ENABLE     = 0;
   localparam int unsigned FC_TX_CLEAR   = 2;
   localparam int unsigned FC_TRIG_LO    = 4;
   localparam int unsigned LC_STOP2      = 2;
   localparam int unsigned LC_PAR_EN     = 3;
   localparam int unsigned LC_PAR_EVEN   = 4;
   localparam int unsigned MC_PRESCALE   = 7;
   localparam int unsigned LS_HOLD_EMPTY = 5;
   localparam int unsigned LS_SHIFT_EMPTY = 6;
   localparam logic [7:0]  FC_KEEP_MASK  = 8'h31;
   localparam logic [3:0]  FRAC_MASK     = 4'hf;
   // values after reset
   localparam logic [7:0] RST_INT_EN    = 8'h00;
   localparam logic [7:0] RST_FIFO_CTL  = 8'h00;
   localparam logic [7:0] RST_LINE_CTL  = 8'h00;
   localparam logic [7:0] RST_MODEM_CTL = 8'h00;
   localparam logic [7:0] RST_DIV_LOW   = 8'h01;
   localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
   localparam logic [3:0] RST_DIV_FRAC  = 4'h0;
   localparam logic [7:0] RST_SEL       = 8'h00;
   // sampling ticks per bit minus one: 16x, 8x, 4x
   localparam logic [3:0] LAST_16X = 4'hf;
   localparam logic [3:0] LAST_8X  = 4'h7;
   localparam logic [3:0] LAST_4X  = 4'h3;
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   // transmit trigger levels, selected by two fifo control bits
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0c;
   typedef enum logic [2:0] {
      UTP_IDLE   = 3'b000,
      UTP_START  = 3'b001,
      UTP_DATA   = 3'b011,
      UTP_PARITY = 3'b010,
      UTP_STOP   = 3'b110
   } utp_tx_state_t;
endpackage : utp_pkg

//--- hdl/utp_baud_gen.sv
// fractional baud generator: prescaler then divisor of int + frac/16
// assumes divisor inputs held stable by the register file
`timescale 1ns/1ps
module utp_baud_gen
   import utp_pkg::*;
#(
   parameter int unsigned INT_W = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clr_i,
   input  wire logic             prescale4_i,
   input  wire logic [INT_W-1:0] div_int_i,
   input  wire logic [3:0]       div_frac_i,
   output logic                  tick_o
);
   if (INT_W < 2) begin : g_chk
      $error("utp_baud_gen: INT_W too small");
   end
   logic [1:0]     pre_reg, pre_next;
   logic [INT_W:0] cnt_reg, cnt_next, limit;
   logic [3:0]     acc_reg, acc_next;
   logic           ext_reg, ext_next, tick_reg, tick_next, pre_en;

   always_comb begin
      pre_next  = prescale4_i ? pre_reg + 2'h1 : 2'h0;
      pre_en    = !prescale4_i || (pre_reg == PRESCALE_LAST);
      cnt_next  = cnt_reg;
      acc_next  = acc_reg;
      ext_next  = ext_reg;
      tick_next = 1'b0;
      // a zero integer part behaves as one
      limit = (div_int_i == '0) ? (INT_W+1)'(1) : {1'b0, div_int_i};
      limit = limit + (INT_W+1)'(ext_reg);
      if (pre_en) begin
         if (cnt_reg + (INT_W+1)'(1) >= limit) begin
            cnt_next  = '0;
            // sixteenths carry into one longer period
            {ext_next, acc_next} = {1'b0, acc_reg} + {1'b0, div_frac_i};
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + (INT_W+1)'(1);
         end
      end
      if (clr_i) begin
         pre_next = 2'h0;
         cnt_next = '0;
         acc_next = 4'h0;
         ext_next = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_reg  <= 2'h0;
         cnt_reg  <= '0;
         acc_reg  <= 4'h0;
         ext_reg  <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         pre_reg  <= pre_next;
         cnt_reg  <= cnt_next;
         acc_reg  <= acc_next;
         ext_reg  <= ext_next;
         tick_reg <= tick_next;
      end
   end
   assign tick_o = tick_reg;
endmodule : utp_baud_gen

//--- hdl/utp_tx_fifo.sv
// transmit byte fifo in flip-flops; single mode makes it one holding slot
// assumes the reader pops only while valid is high
`timescale 1ns/1ps
module utp_tx_fifo
   import utp_pkg::*;
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16,
   localparam int unsigned AW   = $clog2(DEPTH)
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             clr_i,
   input  wire logic             single_i,
   input  wire logic             wr_valid_i,
   input  wire logic [WIDTH-1:0] wr_data_i,
   output logic                  wr_ready_o,
   output logic                  rd_valid_o,
   output logic [WIDTH-1:0]      rd_data_o,
   input  wire logic             rd_ready_i,
   output logic [AW:0]           count_o
);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("utp_tx_fifo: DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   always_comb begin
      wr_ready_o = single_i ? (cnt_reg == '0)
                            : (cnt_reg != (AW+1)'(DEPTH));
      rd_valid_o = (cnt_reg != '0);
      rd_data_o  = mem_reg[rp_reg];
      push       = wr_valid_i && wr_ready_o;
      pop        = rd_ready_i && rd_valid_o;
      mem_next   = mem_reg;
      wp_next    = wp_reg;
      rp_next    = rp_reg;
      cnt_next   = cnt_reg;
      if (push) begin
         mem_next[wp_reg] = wr_data_i;
         wp_next = wp_reg + AW'(1);
      end
      if (pop) begin
         rp_next = rp_reg + AW'(1);
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_next = cnt_reg - (AW+1)'(1);
      end
      if (clr_i) begin
         wp_next  = '0;
         rp_next  = '0;
         cnt_next = '0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '0;
         end
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         mem_reg <= mem_next;
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end
   assign count_o = cnt_reg;
endmodule : utp_tx_fifo

//--- hdl/utp_top.sv
// serial transmit path of one channel with its avalon-mm register file
// assumes a single 20 MHz clock that is also the baud reference
// Summary of operation
// - eight-bit shifter fed from a sixteen-byte fifo.
// - one bit lasts 16 sampling ticks, or 8 or 4 in reduced modes.
// - eight- and four-times select registers pick reduced modes.
// - frame is start, data, optional parity, then stop bits.
// - data leaves least significant bit first.
// - fifo control bit 0 enables the fifo; otherwise one holding slot.
// - a holding write with room free stores the byte and bumps the write pointer.
// - no fifo: line status bit 5 sets as the byte enters shifter.
// - holding empty raises interrupt status bit 1 if enable bit 1.
// - no fifo: line status bit 6 sets when the shifter is empty.
// - fifo: line status bit 5 is set while the fifo is empty.
// - fifo: interrupt raised when level falls below trigger.
// - fifo: bit 6 sets only when shifter and fifo are both empty.
// - divisor integer in high and low bytes, fraction in sixteenths.
// - modem control bit 7 prescales the reference by one or four.
// - only four low bits of the fraction register exist.
// - divisor resets to one: low byte one, high and fraction zero.
// - generator output is the sampling clock that times shifting.
`timescale 1ns/1ps
module utp_top
   import utp_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   output logic                   txd_o,
   output logic                   tx_int_o
);
   localparam int unsigned AW = $clog2(FIFO_DEPTH);

   logic [7:0]    int_en_reg, int_en_next, fifo_ctl_reg, fifo_ctl_next;
   logic [7:0]    line_ctl_reg, line_ctl_next, modem_ctl_reg, modem_ctl_next;
   logic [7:0]    div_low_reg, div_low_next, divisor_high_byte_reg;
   logic [7:0]    divisor_high_byte_next;
   logic [3:0]    divisor_fraction_reg, divisor_fraction_next;
   logic [7:0]    sel8_reg, sel8_next, sel4_reg, sel4_next;
   logic [31:0]   rdata_reg, rdata_next;
   logic          wait_reg, wait_next, srst_reg, srst_next;
   logic          int_reg, int_next;
   logic [7:0]    rd_val, wd;
   logic          wr_take, fifo_push, fifo_clr, fifo_ready;
   logic          fifo_valid, fifo_pop, tick, hold_empty, shift_empty;
   logic [7:0]    fifo_data;
   logic [AW:0]   fifo_count;
   logic [4:0]    trig;
   logic [3:0]    last_smp;

   utp_tx_state_t st_reg, st_next;
   logic [3:0]    smp_reg, smp_next;
   logic [2:0]    bit_reg, bit_next;
   logic [7:0]    tx_shift_register_reg, tx_shift_register_next;
   logic          par_reg, par_next, txd_reg, txd_next;
   logic          stop_reg, stop_next;

   utp_baud_gen #(
      .INT_W (16)
   ) u_baud_generator (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .clr_i       (srst_reg),
      .prescale4_i (modem_ctl_reg[MC_PRESCALE]),
      .div_int_i   ({divisor_high_byte_reg, div_low_reg}),
      .div_frac_i  (divisor_fraction_reg),
      .tick_o      (tick)
   );

   utp_tx_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .clr_i      (fifo_clr),
      .single_i   (!fifo_ctl_reg[FC_ENABLE]),
      .wr_valid_i (fifo_push),
      .wr_data_i  (wd),
      .wr_ready_o (fifo_ready),
      .rd_valid_o (fifo_valid),
      .rd_data_o  (fifo_data),
      .rd_ready_i (fifo_pop),
      .count_o    (fifo_count)
   );

   // a full fifo drops the write; the host must watch the level
   assign wd          = avs_writedata_i[7:0];
   assign wr_take     = avs_write_i && !wait_reg;
   assign hold_empty  = !fifo_valid;
   assign shift_empty = hold_empty && (st_reg == UTP_IDLE);

   always_comb begin
      case (fifo_ctl_reg[FC_TRIG_LO +: 2])
         2'h0:    trig = TRIG_0;
         2'h1:    trig = TRIG_1;
         2'h2:    trig = TRIG_2;
         default: trig = TRIG_3;
      endcase
      // both selects set is reserved and falls back to 16x
      if (sel8_reg[0] && !sel4_reg[0]) begin
         last_smp = LAST_8X;
      end else if (sel4_reg[0] && !sel8_reg[0]) begin
         last_smp = LAST_4X;
      end else begin
         last_smp = LAST_16X;
      end
   end

   always_comb begin
      case (avs_address_i)
         OFS_INT_EN:    rd_val = int_en_reg;
         OFS_INT_STAT:  rd_val = {6'h00, int_reg, !int_reg};
         OFS_FIFO_CTL:  rd_val = fifo_ctl_reg;
         OFS_LINE_CTL:  rd_val = line_ctl_reg;
         OFS_MODEM_CTL: rd_val = modem_ctl_reg;
         OFS_LINE_STAT: rd_val = {1'b0, shift_empty, hold_empty, 5'h00};
         OFS_DIV_LOW:   rd_val = div_low_reg;
         OFS_DIV_HIGH:  rd_val = divisor_high_byte_reg;
         OFS_DIV_FRAC:  rd_val = {4'h0, divisor_fraction_reg};
         OFS_SEL_8X:    rd_val = sel8_reg;
         OFS_SEL_4X:    rd_val = sel4_reg;
         default:       rd_val = 8'h00;
      endcase
   end

   always_comb begin
      int_en_next            = int_en_reg;
      fifo_ctl_next          = fifo_ctl_reg;
      line_ctl_next          = line_ctl_reg;
      modem_ctl_next         = modem_ctl_reg;
      div_low_next           = div_low_reg;
      divisor_high_byte_next = divisor_high_byte_reg;
      divisor_fraction_next  = divisor_fraction_reg;
      sel8_next              = sel8_reg;
      sel4_next              = sel4_reg;
      rdata_next             = rdata_reg;
      wait_next              = 1'b1;
      srst_next              = 1'b0;
      fifo_push              = 1'b0;
      fifo_clr               = srst_reg;
      // one wait cycle: sample on the first edge, release on the next
      if ((avs_read_i || avs_write_i) && wait_reg) begin
         wait_next  = 1'b0;
         rdata_next = avs_read_i ? {24'h000000, rd_val} : 32'h00000000;
      end
      if (wr_take && avs_byteenable_i[0]) begin
         case (avs_address_i)
            OFS_TX_HOLD:   fifo_push = 1'b1;
            OFS_INT_EN:    int_en_next = wd;
            OFS_FIFO_CTL: begin
               fifo_ctl_next = wd & FC_KEEP_MASK;
               fifo_clr = wd[FC_TX_CLEAR] ||
                          (wd[FC_ENABLE] != fifo_ctl_reg[FC_ENABLE]);
            end
            OFS_LINE_CTL:  line_ctl_next = wd;
            OFS_MODEM_CTL: modem_ctl_next = wd;
            OFS_DIV_LOW:   div_low_next = wd;
            OFS_DIV_HIGH:  divisor_high_byte_next = wd;
            OFS_DIV_FRAC:  divisor_fraction_next = wd[3:0] & FRAC_MASK;
            OFS_SEL_8X:    sel8_next = wd;
            OFS_SEL_4X:    sel4_next = wd;
            OFS_SOFT_RST:  srst_next = 1'b1;
            default: begin
            end
         endcase
      end
      // level below trigger in fifo mode, plain holding empty otherwise
      int_next = int_en_reg[IE_TX_EMPTY] &&
                 (fifo_ctl_reg[FC_ENABLE] ? ({1'b0, fifo_count} < {1'b0, trig})
                                          : hold_empty);
      if (srst_reg) begin
         int_en_next            = RST_INT_EN;
         fifo_ctl_next          = RST_FIFO_CTL;
         line_ctl_next          = RST_LINE_CTL;
         modem_ctl_next         = RST_MODEM_CTL;
         div_low_next           = RST_DIV_LOW;
         divisor_high_byte_next = RST_DIV_HIGH;
         divisor_fraction_next  = RST_DIV_FRAC;
         sel8_next              = RST_SEL;
         sel4_next              = RST_SEL;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_en_reg <= RST_INT_EN;
         fifo_ctl_reg <= RST_FIFO_CTL;
         line_ctl_reg <= RST_LINE_CTL;
         modem_ctl_reg <= RST_MODEM_CTL;
         div_low_reg <= RST_DIV_LOW;
         divisor_high_byte_reg <= RST_DIV_HIGH;
         divisor_fraction_reg <= RST_DIV_FRAC;
         sel8_reg <= RST_SEL;
         sel4_reg <= RST_SEL;
         rdata_reg <= 32'h00000000;
         wait_reg <= 1'b1;
         srst_reg <= 1'b0;
         int_reg <= 1'b0;
      end else begin
         int_en_reg <= int_en_next;
         fifo_ctl_reg <= fifo_ctl_next;
         line_ctl_reg <= line_ctl_next;
         modem_ctl_reg <= modem_ctl_next;
         div_low_reg <= div_low_next;
         divisor_high_byte_reg <= divisor_high_byte_next;
         divisor_fraction_reg <= divisor_fraction_next;
         sel8_reg <= sel8_next;
         sel4_reg <= sel4_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
         srst_reg <= srst_next;
         int_reg <= int_next;
      end
   end

   // serialiser; the start bit begins at once, not on a tick boundary
   always_comb begin
      st_next                = st_reg;
      smp_next               = smp_reg;
      bit_next               = bit_reg;
      tx_shift_register_next = tx_shift_register_reg;
      par_next               = par_reg;
      txd_next               = txd_reg;
      stop_next              = stop_reg;
      fifo_pop               = 1'b0;
      case (st_reg)
         UTP_IDLE: begin
            txd_next = 1'b1;
            if (fifo_valid) begin
               fifo_pop = 1'b1;
               tx_shift_register_next = fifo_data;
               par_next = ^(fifo_data & (8'hff >> (2'h3 - line_ctl_reg[1:0])))
                          ^ !line_ctl_reg[LC_PAR_EVEN];
               smp_next = 4'h0;
               txd_next = 1'b0;
               st_next  = UTP_START;
            end
         end
         default: begin
            if (tick) begin
               if (smp_reg != last_smp) begin
                  smp_next = smp_reg + 4'h1;
               end else begin
                  smp_next = 4'h0;
                  case (st_reg)
                     UTP_START: begin
                        bit_next = 3'h0;
                        txd_next = tx_shift_register_reg[0];
                        st_next  = UTP_DATA;
                     end
                     UTP_DATA: begin
                        if (bit_reg == {1'b1, line_ctl_reg[1:0]}) begin
                           stop_next = 1'b0;
                           if (line_ctl_reg[LC_PAR_EN]) begin
                              txd_next = par_reg;
                              st_next  = UTP_PARITY;
                           end else begin
                              txd_next = 1'b1;
                              st_next  = UTP_STOP;
                           end
                        end else begin
                           tx_shift_register_next =
                              {1'b0, tx_shift_register_reg[7:1]};
                           txd_next = tx_shift_register_reg[1];
                           bit_next = bit_reg + 3'h1;
                        end
                     end
                     UTP_PARITY: begin
                        txd_next = 1'b1;
                        st_next  = UTP_STOP;
                     end
                     UTP_STOP: begin
                        if (line_ctl_reg[LC_STOP2] && !stop_reg) begin
                           stop_next = 1'b1;
                        end else begin
                           st_next = UTP_IDLE;
                        end
                     end
                     default: st_next = UTP_IDLE;
                  endcase
               end
            end
         end
      endcase
      if (srst_reg) begin
         st_next  = UTP_IDLE;
         txd_next = 1'b1;
         fifo_pop = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg <= UTP_IDLE;
         smp_reg <= 4'h0;
         bit_reg <= 3'h0;
         tx_shift_register_reg <= 8'h00;
         par_reg <= 1'b0;
         txd_reg <= 1'b1;
         stop_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         smp_reg <= smp_next;
         bit_reg <= bit_next;
         tx_shift_register_reg <= tx_shift_register_next;
         par_reg <= par_next;
         txd_reg <= txd_next;
         stop_reg <= stop_next;
      end
   end

   assign avs_readdata_o    = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign txd_o             = txd_reg;
   assign tx_int_o          = int_reg;
endmodule : utp_top

//--- test/utp_sva.sv
// checker: bus handshake, interrupt and serial timing of utp_top
// assumes binding onto utp_top with one clock domain
`timescale 1ns/1ps
module utp_sva
   import utp_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   input  wire logic [31:0]       avs_readdata_o,
   input  wire logic              avs_waitrequest_o,
   input  wire logic              txd_o,
   input  wire logic              tx_int_o
);
   logic ie_reg, ie_next, wr_ok;
   assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   always_comb begin
      ie_next = ie_reg;
      if (wr_ok && avs_address_i == OFS_INT_EN)
         ie_next = avs_writedata_i[IE_TX_EMPTY];
      if (wr_ok && avs_address_i == OFS_SOFT_RST)
         ie_next = 1'b0;
   end
   always_ff @(posedge clk_i or posedge rst_i)
      if (rst_i) ie_reg <= 1'b0;
      else ie_reg <= ie_next;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // shortest bit is 4 ticks; a late start loses under one tick
   property p_bit; $changed(txd_o) |=> $stable(txd_o) [*2]; endproperty
   a_bit: assert property (p_bit) else $error("bit too short");
   property p_idle; $past(rst_i) |-> txd_o && !tx_int_o; endproperty
   a_idle: assert property (p_idle) else $error("not idle at reset");
   // interrupt lags the enable register by up to two stages
   property p_ien; tx_int_o |-> ie_reg || $past(ie_reg) || $past(ie_reg, 2);
   endproperty
   a_ien: assert property (p_ien) else $error("int not enabled");
   property p_ans; (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
   a_one: assert property (p_one) else $error("answer held too long");
   property p_quiet; !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("idle answer");
   property p_frac; !avs_waitrequest_o && avs_read_i
      && avs_address_i == OFS_DIV_FRAC |-> avs_readdata_o[7:4] == 4'h0;
   endproperty
   a_frac: assert property (p_frac) else $error("fraction too wide");
   property p_unmap; !avs_waitrequest_o && avs_read_i
      && avs_address_i == 6'h3c |-> avs_readdata_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : utp_sva
bind utp_top utp_sva i_sva (.clk_i, .rst_i, .avs_address_i, .avs_read_i,
   .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
   .avs_waitrequest_o, .txd_o, .tx_int_o);

//--- test/utp_rx_model.sv
// remote serial receiver sampling each bit in its middle
// assumes the bench sets bit length in clocks and the frame format
`timescale 1ns/1ps
module utp_rx_model (
   input  wire logic        clk_i,
   input  wire logic        rxd_i,
   input  wire logic [15:0] bit_clks_i,
   input  wire logic [3:0]  nbits_i,
   input  wire logic        par_en_i,
   output logic [7:0]       byte_o,
   output logic             par_o,
   output logic             stop_o,
   output logic [7:0]       cnt_o
);
   initial begin
      cnt_o = 8'h0;
      forever begin
         @(negedge rxd_i);
         repeat (bit_clks_i / 2) @(posedge clk_i);
         byte_o = 8'h0;
         par_o = 1'b0;
         for (int i = 0; i < nbits_i; i++) begin
            repeat (bit_clks_i) @(posedge clk_i);
            byte_o[i] = rxd_i;
         end
         repeat (bit_clks_i) @(posedge clk_i);
         if (par_en_i) par_o = rxd_i;
         if (par_en_i) repeat (bit_clks_i) @(posedge clk_i);
         stop_o = rxd_i;
         cnt_o++;
      end
   end
endmodule : utp_rx_model

//--- test/utp_top_tb_top.sv
// bench: frames, bit timing, status, fifo and interrupt of utp_top
// assumes utp_rx_model decodes txd_o with the bit length set here
`timescale 1ns/1ps
module utp_top_tb_top
   import utp_pkg::*;
;
   typedef struct {logic [7:0] lcr, d, b; logic p;} utp_frame_t;
   typedef struct {logic [7:0] s8, s4, mc, dl; int len;} utp_time_t;
   logic        clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0;
   logic [5:0]  avs_address_i = 0;
   logic [31:0] avs_writedata_i = 0, avs_readdata_o, q;
   logic        avs_waitrequest_o, txd_o, tx_int_o, par_en = 0;
   logic        rx_par, rx_stop;
   logic [15:0] bit_clks = 16;
   logic [3:0]  nbits = 8;
   logic [7:0]  rx_byte, rx_cnt;
   int          n_errors = 0, checked = 0, n;
   utp_frame_t rows [5] = '{'{8'h03, 8'ha5, 8'ha5, 0},
      '{8'h00, 8'hff, 8'h1f, 0}, '{8'h0b, 8'h07, 8'h07, 0},
      '{8'h1b, 8'h07, 8'h07, 1}, '{8'h1d, 8'h33, 8'h33, 0}};
   utp_time_t tim [6] = '{'{0, 0, 0, 1, 16}, '{1, 0, 0, 1, 8},
      '{1, 1, 0, 1, 16}, '{0, 1, 0, 1, 4}, '{0, 1, 8'h80, 1, 16},
      '{0, 0, 0, 3, 48}};
   utp_top i_dut (.clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o,
      .avs_waitrequest_o, .txd_o, .tx_int_o);
   utp_rx_model i_rx (.clk_i, .rxd_i(txd_o), .bit_clks_i(bit_clks),
      .nbits_i(nbits), .par_en_i(par_en), .byte_o(rx_byte), .par_o(rx_par),
      .stop_o(rx_stop), .cnt_o(rx_cnt));
   task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      avs_read_i <= !w;
      avs_write_i <= w;
      @(posedge clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
      q = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task chk(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task rdchk(input logic [5:0] a, input logic [31:0] e);
      bus(0, a, 8'h0);
      chk(q, e);
   endtask : rdchk
   task wait_rx(input logic [7:0] c);
      while (rx_cnt !== c) @(posedge clk_i);
   endtask : wait_rx
   task bitlen;
      n = 0;
      while (txd_o !== 1'b0) @(posedge clk_i);
      while (txd_o !== 1'b1) @(posedge clk_i);
      while (txd_o === 1'b1) begin
         @(posedge clk_i);
         n++;
      end
   endtask : bitlen
   task do_reset;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset
   task tally_and_finish;
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   initial forever #25 clk_i = ~clk_i;
   initial begin
      repeat (40000) @(posedge clk_i);
      n_errors++;
      tally_and_finish;
   end
   initial begin
      do_reset;
      foreach (rows[i]) begin
         nbits = 4'd5 + {2'b0, rows[i].lcr[1:0]};
         par_en = rows[i].lcr[3];
         bus(1, OFS_LINE_CTL, rows[i].lcr);
         bus(1, OFS_TX_HOLD, rows[i].d);
         wait_rx(rx_cnt + 8'h1);
         q = {rx_stop, rx_par, rx_byte};
         chk(q, {1'b1, rows[i].p, rows[i].b});
      end
      foreach (tim[i]) begin
         bus(1, OFS_SEL_8X, tim[i].s8);
         bus(1, OFS_SEL_4X, tim[i].s4);
         bus(1, OFS_MODEM_CTL, tim[i].mc);
         bus(1, OFS_DIV_LOW, tim[i].dl);
         bit_clks = tim[i].len[15:0];
         bus(1, OFS_TX_HOLD, 8'h01);
         bitlen;
         chk(n, tim[i].len);
         wait_rx(rx_cnt + 8'h1);
         repeat (tim[i].len) @(posedge clk_i);
      end
      // second reset mid-run also checks that the idle line, status and divisor bytes come back
      do_reset;
      chk({txd_o, tx_int_o}, 2'b10);
      rdchk(OFS_LINE_STAT, 32'h60);
      rdchk(OFS_DIV_LOW, 32'h1);
      rdchk(OFS_DIV_HIGH, 32'h0);
      rdchk(OFS_INT_STAT, 32'h1);
      bus(1, OFS_DIV_FRAC, 8'hff);
      rdchk(OFS_DIV_FRAC, 32'hf);
      bus(1, OFS_DIV_FRAC, 8'h0);
      rdchk(6'h3c, 32'h0);
      bit_clks = 16;
      nbits = 8;
      par_en = 0;
      bus(1, OFS_LINE_CTL, 8'h03);
      bus(1, OFS_INT_EN, 8'h02);
      repeat (2) @(posedge clk_i);
      chk(tx_int_o, 1);
      bus(1, OFS_TX_HOLD, 8'h5a);
      rdchk(OFS_LINE_STAT, 32'h20);
      wait_rx(rx_cnt + 8'h1);
      repeat (16) @(posedge clk_i);
      rdchk(OFS_LINE_STAT, 32'h60);
      bus(1, OFS_FIFO_CTL, 8'h11);
      for (int i = 0; i < 5; i++) begin
         bus(1, OFS_TX_HOLD, 8'h10 + i[7:0]);
      end
      repeat (2) @(posedge clk_i);
      chk(tx_int_o, 0);
      rdchk(OFS_LINE_STAT, 32'h0);
      n = rx_cnt;
      for (int i = 0; i < 5; i++) begin
         wait_rx(n[7:0] + i[7:0] + 8'h1);
         chk(rx_byte, 8'h10 + i[7:0]);
         chk(tx_int_o, i > 0);
      end
      repeat (16) @(posedge clk_i);
      rdchk(OFS_LINE_STAT, 32'h60);
      bus(1, OFS_INT_EN, 8'h00);
      repeat (2) @(posedge clk_i);
      chk(tx_int_o, 0);
      bus(1, OFS_DIV_LOW, 8'h05);
      bus(1, OFS_SOFT_RST, 8'h00);
      rdchk(OFS_DIV_LOW, 32'h1);
      tally_and_finish;
   end
endmodule : utp_top_tb_top
